// >>> src/dctom_pkg.sv
`default_nettype none
package dctom_pkg;
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned CLK_PER_MS = CLK_FREQ_HZ / 1000;
  localparam int unsigned CLK_PER_US = CLK_FREQ_HZ / 1_000_000;
  // Discrepancy window as printed, in ms
  localparam int unsigned DISC_TIME_MS = 100;
  localparam int unsigned DISC_CYCLES = DISC_TIME_MS * CLK_PER_MS;
  // Longest tolerated test pulse, in us
  localparam int unsigned PULSE_MAX_US = 1000;
  localparam int unsigned PULSE_CYCLES = PULSE_MAX_US * CLK_PER_US;
  localparam int unsigned CNT_W = 32;
  localparam logic [7:0] ERR_MAIN_SAFETY = 8'h34;
  localparam logic [3:0] ERR_SUB_NONE = 4'h0;
  localparam logic [3:0] ERR_SUB_DISC = 4'h1;
  localparam logic [3:0] ERR_SUB_SUPPLY = 4'h2;

  typedef enum logic [1:0] {
    DCTOM_RUN = 2'b00,
    DCTOM_WAIT = 2'b01,
    DCTOM_SAFE = 2'b10,
    DCTOM_FAULT = 2'b11
  } dctom_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] main_index;
    logic [3:0] sub_index;
  } dctom_err_t;

  typedef struct packed {
    logic led_green;
    logic led_yellow;
  } dctom_led_t;
endpackage
`default_nettype wire

// >>> src/dctom_pulse_filter.sv
`default_nettype none
// Low pulses shorter than max_width are swallowed; longer lows pass
module dctom_pulse_filter #(
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic raw_in,
  input wire logic [CNT_W-1:0] max_width,
  output logic filt_out
);
  typedef struct packed {
    logic level;
    logic [CNT_W-1:0] cnt;
  } dctom_flt_state_t;

  dctom_flt_state_t st_r;
  dctom_flt_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (raw_in) begin
      st_nxt.cnt = '0;
      st_nxt.level = 1'b1;
    end else if (st_r.level) begin
      if (st_r.cnt >= max_width) begin
        st_nxt.level = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign filt_out = st_r.level;

  AST_SHORT_LOW_HELD: assert property (@(posedge clk) disable iff (reset)
    (st_r.level && !raw_in && st_r.cnt < max_width) |=> filt_out)
    else $error("Short low pulse reached filter output");
  AST_LONG_LOW_DROPS: assert property (@(posedge clk) disable iff (reset)
    (st_r.level && !raw_in && st_r.cnt >= max_width) |=> !filt_out)
    else $error("Long low level not passed as request");
  AST_HIGH_PASSES: assert property (@(posedge clk) disable iff (reset)
    raw_in |=> filt_out)
    else $error("High level not passed by filter");
endmodule
`default_nettype wire

// >>> src/dctom_monitor.sv
`default_nettype none
// Functional notes
// - Torque-off only when both inputs drop to 0 V; no other request path.
// - Settled levels of both inputs compared; disagreement raises an error.
// - Second input must follow within discrepancy window, default 100 ms.
// - Short test pulses are filtered and never trigger torque-off alone.
// - Driver supply is switched and supervised from the input state.
// - Torque-off cuts motor power; no standstill monitoring is done.
// - Status reported on a normally open potential-free feedback contact.
// - Expired discrepancy window reports error 52 sub-index 1.
// - Supply loss with modulation enabled in torque-off reports error 52 sub-index 2.
// - LED yellow while torque-off is active, green otherwise.
module dctom_monitor #(
  parameter int unsigned DISC_CYCLES = dctom_pkg::DISC_CYCLES,
  parameter int unsigned PULSE_CYCLES = dctom_pkg::PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic torque_off_input_a,
  input wire logic torque_off_input_b,
  input wire logic modulation_enable,
  input wire logic driver_supply_ok,
  input wire logic error_ack,
  output logic driver_supply_enable,
  output logic feedback_contact_closed,
  output dctom_pkg::dctom_led_t status_led,
  output dctom_pkg::dctom_err_t error_code
);
  typedef struct packed {
    dctom_pkg::dctom_state_t state;
    logic [dctom_pkg::CNT_W-1:0] disc_cnt;
    logic supply_en;
    logic contact;
    dctom_pkg::dctom_led_t led;
    dctom_pkg::dctom_err_t err;
  } dctom_mon_state_t;

  localparam logic [dctom_pkg::CNT_W-1:0] DISC_LIMIT = dctom_pkg::CNT_W'(DISC_CYCLES);
  localparam logic [dctom_pkg::CNT_W-1:0] PULSE_LIMIT = dctom_pkg::CNT_W'(PULSE_CYCLES);

  dctom_mon_state_t st_r;
  dctom_mon_state_t st_nxt;
  logic filt_a;
  logic filt_b;
  logic both_low;
  logic both_high;

  dctom_pulse_filter #(.CNT_W(dctom_pkg::CNT_W)) u_filt_a (
    .clk(clk),
    .reset(reset),
    .raw_in(torque_off_input_a),
    .max_width(PULSE_LIMIT),
    .filt_out(filt_a)
  );

  dctom_pulse_filter #(.CNT_W(dctom_pkg::CNT_W)) u_filt_b (
    .clk(clk),
    .reset(reset),
    .raw_in(torque_off_input_b),
    .max_width(PULSE_LIMIT),
    .filt_out(filt_b)
  );

  assign both_low = !filt_a && !filt_b;
  assign both_high = filt_a && filt_b;

  function automatic dctom_pkg::dctom_err_t make_err(input logic [3:0] sub);
    make_err.valid = 1'b1;
    make_err.main_index = dctom_pkg::ERR_MAIN_SAFETY;
    make_err.sub_index = sub;
  endfunction

  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      dctom_pkg::DCTOM_RUN: begin
        if (both_low) begin
          st_nxt.state = dctom_pkg::DCTOM_SAFE;
        end else if (!both_high) begin
          st_nxt.state = dctom_pkg::DCTOM_WAIT;
          st_nxt.disc_cnt = '0;
        end
      end
      dctom_pkg::DCTOM_WAIT: begin
        // Driver supply off and contact open while one channel alone is low
        if (both_low) begin
          st_nxt.state = dctom_pkg::DCTOM_SAFE;
          st_nxt.disc_cnt = '0;
        end else if (both_high) begin
          st_nxt.state = dctom_pkg::DCTOM_RUN;
          st_nxt.disc_cnt = '0;
        end else if (st_r.disc_cnt >= DISC_LIMIT - 1'b1) begin
          st_nxt.state = dctom_pkg::DCTOM_FAULT;
          st_nxt.err = make_err(dctom_pkg::ERR_SUB_DISC);
        end else begin
          st_nxt.disc_cnt = st_r.disc_cnt + 1'b1;
        end
      end
      dctom_pkg::DCTOM_SAFE: begin
        if (!both_low) begin
          // Leaving safe state also needs agreement within the window
          st_nxt.state = both_high ? dctom_pkg::DCTOM_RUN : dctom_pkg::DCTOM_WAIT;
          st_nxt.disc_cnt = '0;
        end
      end
      dctom_pkg::DCTOM_FAULT: begin
        // Latched until acknowledged with both inputs low
        if (error_ack && both_low) begin
          st_nxt.state = dctom_pkg::DCTOM_SAFE;
          st_nxt.err = '0;
        end
      end
      default: begin
        st_nxt.state = dctom_pkg::DCTOM_FAULT;
      end
    endcase

    // Supply removed under live modulation; wins over the ack clear, replaced by a later discrepancy error
    if (!driver_supply_ok && modulation_enable && st_r.supply_en == 1'b0
        && st_nxt.state == dctom_pkg::DCTOM_SAFE) begin
      st_nxt.err = make_err(dctom_pkg::ERR_SUB_SUPPLY);
    end

    st_nxt.supply_en = (st_nxt.state == dctom_pkg::DCTOM_RUN);
    st_nxt.contact = (st_nxt.state == dctom_pkg::DCTOM_SAFE);
    st_nxt.led.led_yellow = (st_nxt.state == dctom_pkg::DCTOM_SAFE);
    st_nxt.led.led_green = (st_nxt.state != dctom_pkg::DCTOM_SAFE);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.state <= dctom_pkg::DCTOM_SAFE;
      st_r.disc_cnt <= '0;
      st_r.supply_en <= 1'b0;
      st_r.contact <= 1'b1;
      st_r.led <= 2'b01;
      st_r.err <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign driver_supply_enable = st_r.supply_en;
  assign feedback_contact_closed = st_r.contact;
  assign status_led = st_r.led;
  assign error_code = st_r.err;

  AST_SAFE_NO_SUPPLY: assert property (@(posedge clk) disable iff (reset)
    (st_r.state == dctom_pkg::DCTOM_SAFE) |-> !driver_supply_enable)
    else $error("Driver supply on in torque-off");
  AST_BOTH_LOW_SAFE: assert property (@(posedge clk) disable iff (reset)
    (both_low && st_r.state != dctom_pkg::DCTOM_FAULT)
     |=> (st_r.state == dctom_pkg::DCTOM_SAFE))
    else $error("Both channels low without torque-off");
  AST_ONE_LOW_NO_SAFE: assert property (@(posedge clk) disable iff (reset)
    (st_r.state == dctom_pkg::DCTOM_RUN && filt_a && !filt_b)
     |=> (st_r.state == dctom_pkg::DCTOM_WAIT))
    else $error("Single channel caused wrong transition");
  AST_DISC_EXPIRE: assert property (@(posedge clk) disable iff (reset)
    (st_r.state == dctom_pkg::DCTOM_WAIT && st_r.disc_cnt == DISC_LIMIT - 1'b1 && !both_low
     && !both_high) |=> (st_r.state == dctom_pkg::DCTOM_FAULT))
    else $error("Discrepancy expiry missed");
  AST_DISC_CODE: assert property (@(posedge clk) disable iff (reset)
    ($rose(st_r.state == dctom_pkg::DCTOM_FAULT)) |-> (error_code.valid
     && error_code.main_index == dctom_pkg::ERR_MAIN_SAFETY
     && error_code.sub_index == dctom_pkg::ERR_SUB_DISC))
    else $error("Wrong discrepancy error code");
  AST_AGREE_CLEARS: assert property (@(posedge clk) disable iff (reset)
    (st_r.state == dctom_pkg::DCTOM_WAIT && both_high) |=> (st_r.disc_cnt == '0
     && st_r.state == dctom_pkg::DCTOM_RUN))
    else $error("Agreement did not clear timer");
  AST_LED_MATCH: assert property (@(posedge clk) disable iff (reset)
    status_led.led_yellow == feedback_contact_closed
     && status_led.led_green == !feedback_contact_closed)
    else $error("LED disagrees with torque-off state");
  AST_CONTACT_OPEN_RUN: assert property (@(posedge clk) disable iff (reset)
    driver_supply_enable |-> !feedback_contact_closed)
    else $error("Contact closed while running");
  AST_SUPPLY_CODE: assert property (@(posedge clk) disable iff (reset)
    (st_r.state == dctom_pkg::DCTOM_SAFE && !st_r.supply_en && !driver_supply_ok
     && modulation_enable && both_low) |=> (error_code.sub_index == dctom_pkg::ERR_SUB_SUPPLY))
    else $error("Supply loss error missed");

  // Timer, latched fault, driver supply and contact must not drift, or a late channel goes unnoticed
  AST_MIXED_NO_SUPPLY: assert property (@(posedge clk) disable iff (reset)
    !both_high |=> !driver_supply_enable)
    else $error("Driver supply on without both channels high");
  AST_RUN_TIMER_IDLE: assert property (@(posedge clk) disable iff (reset)
    (st_r.state == dctom_pkg::DCTOM_RUN) |-> (st_r.disc_cnt == '0))
    else $error("Discrepancy timer not idle while running");
  AST_TIMER_BOUND: assert property (@(posedge clk) disable iff (reset)
    st_r.disc_cnt < DISC_LIMIT)
    else $error("Discrepancy timer past its window");
  AST_TIMER_COUNTS: assert property (@(posedge clk) disable iff (reset)
    (st_r.state == dctom_pkg::DCTOM_WAIT && !both_low && !both_high
     && st_r.disc_cnt < DISC_LIMIT - 1'b1)
     |=> (st_r.state == dctom_pkg::DCTOM_WAIT && st_r.disc_cnt == $past(st_r.disc_cnt) + 1'b1))
    else $error("Discrepancy timer did not advance");
  AST_FAULT_FROM_WAIT: assert property (@(posedge clk) disable iff (reset)
    $rose(st_r.state == dctom_pkg::DCTOM_FAULT)
     |-> ($past(st_r.state) == dctom_pkg::DCTOM_WAIT))
    else $error("Fault entered from outside the discrepancy wait");
  AST_FAULT_LATCHED: assert property (@(posedge clk) disable iff (reset)
    (st_r.state == dctom_pkg::DCTOM_FAULT && !(error_ack && both_low))
     |=> (st_r.state == dctom_pkg::DCTOM_FAULT))
    else $error("Fault released without acknowledge");
  AST_ERR_STICKY: assert property (@(posedge clk) disable iff (reset)
    (error_code.valid && !(st_r.state == dctom_pkg::DCTOM_FAULT && error_ack && both_low))
     |=> error_code.valid)
    else $error("Error code cleared without acknowledge");
  AST_ACK_RECOVERS: assert property (@(posedge clk) disable iff (reset)
    (st_r.state == dctom_pkg::DCTOM_FAULT && error_ack && both_low && driver_supply_ok)
     |=> (st_r.state == dctom_pkg::DCTOM_SAFE && !error_code.valid))
    else $error("Acknowledge did not release the fault");
  AST_LOW_CLOSES_CONTACT: assert property (@(posedge clk) disable iff (reset)
    (both_low && st_r.state != dctom_pkg::DCTOM_FAULT) |=> feedback_contact_closed)
    else $error("Contact open during torque-off");
endmodule
`default_nettype wire

// >>> verification/dctom_safety_switch.sv
`default_nettype none
// Behavioural safety switching device driving both control channels
module dctom_safety_switch (
  input wire logic clk,
  input wire logic cmd_a,
  input wire logic cmd_b,
  input wire logic feedback_closed,
  output var logic torque_off_input_a = 1'b0,
  output var logic torque_off_input_b = 1'b0,
  output logic diag_safe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both channels move on one edge, so skew only when commanded
  always @(negedge clk) begin
    torque_off_input_a <= cmd_a;
    torque_off_input_b <= cmd_b;
  end
  // Single channel contact, read for diagnostics only
  assign diag_safe = feedback_closed;
  // Channel short detection would sit here; the bench never shorts them
endmodule
`default_nettype wire

// >>> verification/tb_dctom_monitor.sv
`default_nettype none
module tb_dctom_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DISC = 50;
  localparam int unsigned PULSE = 5;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_a = 1'b0;
  logic cmd_b = 1'b0;
  logic mod_en = 1'b0;
  logic supply_ok = 1'b1;
  logic ack = 1'b0;
  logic in_a;
  logic in_b;
  logic supply_en;
  logic contact;
  dctom_pkg::dctom_led_t led;
  dctom_pkg::dctom_err_t err;
  int failures = 0;
  int check_count = 0;

  dctom_monitor #(.DISC_CYCLES(DISC), .PULSE_CYCLES(PULSE)) u_dctom_monitor (
    .clk(clk), .reset(reset), .torque_off_input_a(in_a), .torque_off_input_b(in_b),
    .modulation_enable(mod_en), .driver_supply_ok(supply_ok), .error_ack(ack),
    .driver_supply_enable(supply_en), .feedback_contact_closed(contact),
    .status_led(led), .error_code(err)
  );
  dctom_safety_switch u_dctom_safety_switch (
    .clk(clk), .cmd_a(cmd_a), .cmd_b(cmd_b), .feedback_closed(contact),
    .torque_off_input_a(in_a), .torque_off_input_b(in_b), .diag_safe()
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic set_ch(input logic a, input logic b);
    @(posedge clk);
    cmd_a = a;
    cmd_b = b;
  endtask

  // Bounded wait; a hang ends the run as a mismatch
  task automatic wait_contact(input logic exp);
    for (int i = 0; i < 40 && contact !== exp; i++) @(negedge clk);
    if (contact !== exp) begin
      failures++;
      end_of_test();
    end
  endtask

  task automatic check_out(input logic sup, input logic fb, input logic [1:0] l);
    check("supply", {15'h0000, supply_en}, {15'h0000, sup});
    check("contact", {15'h0000, contact}, {15'h0000, fb});
    check("led", {14'h0000, led}, {14'h0000, l});
  endtask

  task automatic do_reset();
    @(negedge clk);
    reset = 1'b1;
    mod_en = 1'b0;
    supply_ok = 1'b1;
    repeat (20) @(negedge clk);
    check_out(1'b0, 1'b1, 2'b01);
    check("err", {3'h0, err}, 16'h0000);
    reset = 1'b0;
  endtask

  task automatic scn_run();
    set_ch(1'b1, 1'b1);
    wait_contact(1'b0);
    check_out(1'b1, 1'b0, 2'b10);
  endtask

  task automatic scn_test_pulse();
    logic seen;
    seen = 1'b0;
    set_ch(1'b0, 1'b0);
    repeat (2) @(posedge clk);
    set_ch(1'b1, 1'b1);
    repeat (20) begin
      @(negedge clk);
      seen = seen | contact | ~supply_en;
    end
    check("pulse", {15'h0000, seen}, 16'h0000);
  endtask

  task automatic scn_safe();
    set_ch(1'b0, 1'b0);
    wait_contact(1'b1);
    check_out(1'b0, 1'b1, 2'b01);
  endtask

  task automatic scn_supply();
    @(negedge clk);
    mod_en = 1'b1;
    supply_ok = 1'b0;
    repeat (2) @(negedge clk);
    check("err", {3'h0, err}, {3'h0, 1'b1, 8'h34, 4'h2});
  endtask

  task automatic scn_disc();
    set_ch(1'b0, 1'b1);
    repeat (40) @(negedge clk);
    check_out(1'b0, 1'b0, 2'b10);
    set_ch(1'b1, 1'b1);
    repeat (10) @(negedge clk);
    set_ch(1'b0, 1'b1);
    repeat (40) @(negedge clk);
    // Timer restarted on agreement, so no fault yet
    check("early", {15'h0000, err.valid}, 16'h0000);
    for (int i = 0; i < 60 && err.valid !== 1'b1; i++) @(negedge clk);
    if (err.valid !== 1'b1) begin
      failures++;
      end_of_test();
    end
    check("err", {3'h0, err}, {3'h0, 1'b1, 8'h34, 4'h1});
    check_out(1'b0, 1'b0, 2'b10);
  endtask

  // Fault holds with both channels low until acknowledged
  task automatic scn_ack();
    set_ch(1'b0, 1'b0);
    repeat (10) @(negedge clk);
    check("latched", {15'h0000, contact}, 16'h0000);
    ack = 1'b1;
    wait_contact(1'b1);
    @(negedge clk);
    ack = 1'b0;
    check("ack err", {3'h0, err}, 16'h0000);
    check_out(1'b0, 1'b1, 2'b01);
  endtask

  initial begin
    do_reset();
    scn_run();
    scn_test_pulse();
    scn_safe();
    scn_supply();
    do_reset();
    scn_run();
    scn_disc();
    scn_ack();
    end_of_test();
  end
endmodule
`default_nettype wire
